// file: core/smw_waveform_gen.sv
// Read and write strobe waveform generator of the static memory controller
`timescale 1ns/1ps
// Function
// R01 - Byte select lines change together with the address, never mid-access.
// R02 - Address drives all bits, bit 0 cleared, or bits 1:0 cleared by width.
// R03 - Read strobe falls after setup, stays low pulse, address held for hold.
// R04 - Chip select in reads has its own setup, pulse and hold counts.
// R05 - Read lasts the read cycle count; hold is cycle minus setup minus pulse.
// R06 - Each chip select owns its read strobe and chip select read timings.
// R07 - Zero setup and hold keeps read strobes low across consecutive reads.
// R08 - Software programs every pulse count to at least one cycle.
// R09 - Read mode setting, not a timing comparison, picks the sampling signal.
// R10 - Read mode one samples data at the read strobe rising edge.
// R11 - Read mode zero samples data at the chip select rising edge.
// R12 - Write strobe falls after setup, low for pulse, data held for hold.
// R13 - Every per-byte write line follows the single write strobe waveform; the code pulses only the lines of enabled byte lanes.
// R14 - Chip select in writes uses its own write setup, pulse and hold.
// R15 - Write lasts the write cycle count; hold derived from cycle.
// R16 - Each chip select owns its write strobe and chip select write timings.
// R17 - Zero setup keeps write strobes low across consecutive writes; the code needs zero hold as well.
// R18 - Software gives rising-edge latching memories a setup or a hold.
// R19 - Write mode setting picks which signal times the data drive.
// R20 - Write mode one drives data from write strobe setup end to cycle end.
// R21 - Write mode zero drives data from chip select setup end to cycle end.
// R22 - Setup, pulse and cycle fields decode with their weighted top bits.
// R23 - Software keeps setup plus pulse within the cycle count.
// R24 - All strobes and selects are active low and high while idle.
// R25 - Write data drive is released at the end of the write cycle.
module smw_waveform_gen (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Access request from the internal bus
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [smw_pkg::CS_W-1:0] req_cs_i,
   input wire logic [smw_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic [smw_pkg::LANES-1:0] req_be_i,
   input wire logic [smw_pkg::DATA_W-1:0] req_wdata_i,
   output logic req_ready_o,
   // Read answer
   output logic rd_valid_o,
   output logic [smw_pkg::DATA_W-1:0] rd_data_o,
   // Per chip select read timing
   input wire logic [7:0][smw_pkg::SETUP_W-1:0] rd_strobe_setup_cnt_i,
   input wire logic [7:0][smw_pkg::PULSE_W-1:0] rd_strobe_pulse_cnt_i,
   input wire logic [7:0][smw_pkg::CYCLE_W-1:0] rd_cycle_cnt_i,
   input wire logic [7:0][smw_pkg::SETUP_W-1:0] cs_read_setup_cnt_i,
   input wire logic [7:0][smw_pkg::PULSE_W-1:0] cs_read_pulse_cnt_i,
   // Per chip select write timing
   input wire logic [7:0][smw_pkg::SETUP_W-1:0] wr_strobe_setup_cnt_i,
   input wire logic [7:0][smw_pkg::PULSE_W-1:0] wr_strobe_pulse_cnt_i,
   input wire logic [7:0][smw_pkg::CYCLE_W-1:0] wr_cycle_cnt_i,
   input wire logic [7:0][smw_pkg::SETUP_W-1:0] cs_write_setup_cnt_i,
   input wire logic [7:0][smw_pkg::PULSE_W-1:0] cs_write_pulse_cnt_i,
   // Per chip select mode
   input wire logic [7:0][1:0] data_width_i,
   input wire logic [7:0] byte_write_mode_i,
   input wire logic [7:0] read_mode_i,
   input wire logic [7:0] write_mode_i,
   // Memory pins
   output logic [smw_pkg::ADDR_W-1:0] addr_o,
   output logic [smw_pkg::LANES-1:0] byte_select_line_n_o,
   output logic write_strobe_n_o,
   output logic [smw_pkg::LANES-1:0] byte_write_strobe_n_o,
   output logic read_strobe_n_o,
   output logic [smw_pkg::CS_NUM-1:0] chip_select_line_n_o,
   output logic [smw_pkg::DATA_W-1:0] data_o,
   output logic data_oe_o,
   input wire logic [smw_pkg::DATA_W-1:0] data_i
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   smw_pkg::smw_state_e state;
   logic [smw_pkg::EFF_W-1:0] cnt;
   logic cur_write;
   logic [smw_pkg::CS_W-1:0] cur_cs;
   logic [smw_pkg::ADDR_W-1:0] cur_addr;
   logic [smw_pkg::LANES-1:0] cur_lanes;
   logic [smw_pkg::DATA_W-1:0] cur_wdata;
   logic [1:0] cur_dbw;
   logic cur_bwr;
   logic cur_rmode;
   logic cur_wmode;
   logic [smw_pkg::EFF_W-1:0] s_setup;
   logic [smw_pkg::EFF_W-1:0] s_pulse;
   logic [smw_pkg::EFF_W-1:0] c_setup;
   logic [smw_pkg::EFF_W-1:0] c_pulse;
   logic [smw_pkg::EFF_W-1:0] cyc;
   logic [smw_pkg::EFF_W-1:0] dec_s_setup;
   logic [smw_pkg::EFF_W-1:0] dec_s_pulse;
   logic [smw_pkg::EFF_W-1:0] dec_c_setup;
   logic [smw_pkg::EFF_W-1:0] dec_c_pulse;
   logic [smw_pkg::EFF_W-1:0] dec_cyc;
   logic [smw_pkg::EFF_W-1:0] s_end;
   logic [smw_pkg::EFF_W-1:0] c_end;
   logic [smw_pkg::EFF_W-1:0] ctl_end;
   logic [smw_pkg::EFF_W-1:0] wctl_setup;
   logic s_lo;
   logic c_lo;
   logic busy;
   logic last;
   logic take;
   logic next_ready;
   logic [smw_pkg::CAP_DLY-1:0] rd_pend;
   logic [smw_pkg::DATA_W-1:0] data_sync1;
   logic [smw_pkg::DATA_W-1:0] data_sync2;
   logic [smw_pkg::ADDR_W-1:0] req_addr_al;

   // ----------------------------------------------------------------
   // Timing decode of the requested chip select
   // ----------------------------------------------------------------
   smw_cfg_decode u_decode (
      .strobe_setup_i (req_write_i ? wr_strobe_setup_cnt_i[req_cs_i] :
                       rd_strobe_setup_cnt_i[req_cs_i]), // R06 R16
      .strobe_pulse_i (req_write_i ? wr_strobe_pulse_cnt_i[req_cs_i] :
                       rd_strobe_pulse_cnt_i[req_cs_i]),
      .cs_setup_i (req_write_i ? cs_write_setup_cnt_i[req_cs_i] :
                   cs_read_setup_cnt_i[req_cs_i]), // R14
      .cs_pulse_i (req_write_i ? cs_write_pulse_cnt_i[req_cs_i] :
                   cs_read_pulse_cnt_i[req_cs_i]),
      .cycle_i (req_write_i ? wr_cycle_cnt_i[req_cs_i] :
                rd_cycle_cnt_i[req_cs_i]), // R22
      .strobe_setup_o (dec_s_setup),
      .strobe_pulse_o (dec_s_pulse),
      .cs_setup_o (dec_c_setup),
      .cs_pulse_o (dec_c_pulse),
      .cycle_o (dec_cyc)
   );

   // ----------------------------------------------------------------
   // Strobe windows
   // ----------------------------------------------------------------
   smw_strobe_win u_strobe_win (
      .cnt_i (cnt),
      .setup_i (s_setup),
      .pulse_i (s_pulse),
      .active_o (s_lo),
      .end_o (s_end)
   );

   smw_strobe_win u_cs_win (
      .cnt_i (cnt),
      .setup_i (c_setup),
      .pulse_i (c_pulse),
      .active_o (c_lo),
      .end_o (c_end)
   );

   // ----------------------------------------------------------------
   // Access sequencing
   // ----------------------------------------------------------------
   assign busy = (state == smw_pkg::SMW_ACCESS);
   assign last = busy &&
                 (cnt == smw_pkg::EFF_W'(cyc - smw_pkg::ONE_CNT)); // R05 R15
   // Back to back only on the same memory in the same direction
   assign take = req_valid_i && req_ready_o &&
                 (!busy || (req_cs_i == cur_cs &&
                            req_write_i == cur_write)); // R07 R17
   assign ctl_end = cur_rmode ? s_end : c_end; // R09
   assign wctl_setup = cur_wmode ? s_setup : c_setup; // R19

   always_comb begin
      req_addr_al = req_addr_i;
      if (data_width_i[req_cs_i] == smw_pkg::DBW_32) begin
         req_addr_al[1:0] = 2'h0; // R02
      end else if (data_width_i[req_cs_i] == smw_pkg::DBW_16) begin
         req_addr_al[0] = 1'b0; // R02
      end
   end

   always_comb begin
      if (take) begin
         next_ready = (dec_cyc == smw_pkg::MIN_CYCLE);
      end else if (last || !busy) begin
         next_ready = 1'b1;
      end else begin
         next_ready = (smw_pkg::EFF_W'(cnt + smw_pkg::TWO_CNT) == cyc);
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= smw_pkg::SMW_IDLE;
         cnt <= smw_pkg::CNT_RST;
      end else if (take) begin
         state <= smw_pkg::SMW_ACCESS;
         cnt <= smw_pkg::CNT_RST;
      end else if (last) begin
         state <= smw_pkg::SMW_IDLE;
         cnt <= smw_pkg::CNT_RST;
      end else if (busy) begin
         cnt <= smw_pkg::EFF_W'(cnt + smw_pkg::ONE_CNT);
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         req_ready_o <= 1'b0;
      end else begin
         req_ready_o <= next_ready;
      end
   end

   // Access parameters are frozen for the whole access
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cur_write <= 1'b0;
         cur_cs <= smw_pkg::CS_RST;
         cur_addr <= smw_pkg::ADDR_RST;
         cur_lanes <= 4'h0;
         cur_wdata <= smw_pkg::DATA_RST;
         cur_dbw <= smw_pkg::DBW_8;
         cur_bwr <= 1'b0;
         cur_rmode <= 1'b0;
         cur_wmode <= 1'b0;
         s_setup <= smw_pkg::CNT_RST;
         s_pulse <= smw_pkg::ONE_CNT;
         c_setup <= smw_pkg::CNT_RST;
         c_pulse <= smw_pkg::ONE_CNT;
         cyc <= smw_pkg::MIN_CYCLE;
      end else if (take) begin
         cur_write <= req_write_i;
         cur_cs <= req_cs_i;
         cur_addr <= req_addr_al;
         cur_lanes <= req_be_i & smw_pkg::smw_lanes(data_width_i[req_cs_i]);
         cur_wdata <= req_wdata_i;
         cur_dbw <= data_width_i[req_cs_i];
         cur_bwr <= byte_write_mode_i[req_cs_i] &&
                    (data_width_i[req_cs_i] != smw_pkg::DBW_8);
         cur_rmode <= read_mode_i[req_cs_i];
         cur_wmode <= write_mode_i[req_cs_i];
         s_setup <= dec_s_setup;
         s_pulse <= dec_s_pulse;
         c_setup <= dec_c_setup;
         c_pulse <= dec_c_pulse;
         cyc <= dec_cyc;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers, one cycle behind the counter
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         read_strobe_n_o <= 1'b1;
         write_strobe_n_o <= 1'b1;
         byte_write_strobe_n_o <= smw_pkg::LANES_IDLE;
         chip_select_line_n_o <= smw_pkg::CS_IDLE;
      end else begin
         read_strobe_n_o <= !(busy && !cur_write && s_lo); // R03 R24
         write_strobe_n_o <= !(busy && cur_write && s_lo && !cur_bwr); // R12
         byte_write_strobe_n_o <= ~({smw_pkg::LANES{busy && cur_write &&
                                   s_lo && cur_bwr}} & cur_lanes); // R13
         chip_select_line_n_o <= (busy && c_lo) ?
                                 ~(smw_pkg::CS_ONE << cur_cs) :
                                 smw_pkg::CS_IDLE; // R04 R14 R24
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_o <= smw_pkg::ADDR_RST;
         byte_select_line_n_o <= smw_pkg::LANES_IDLE;
      end else begin
         if (busy) begin
            addr_o <= cur_addr; // R02
         end
         byte_select_line_n_o <= ~({smw_pkg::LANES{busy && !cur_bwr &&
                                  cur_dbw != smw_pkg::DBW_8}} &
                                  cur_lanes); // R01 R24
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_o <= smw_pkg::DATA_RST;
         data_oe_o <= 1'b0;
      end else begin
         if (busy && cur_write) begin
            data_o <= cur_wdata;
         end
         data_oe_o <= busy && cur_write && (cnt >= wctl_setup); // R20 R21 R25
      end
   end

   // ----------------------------------------------------------------
   // Read data capture
   // ----------------------------------------------------------------
   // The pin flop samples at the edge that raises the controlling strobe
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_sync1 <= smw_pkg::DATA_RST;
         data_sync2 <= smw_pkg::DATA_RST;
      end else begin
         data_sync1 <= data_i;
         data_sync2 <= data_sync1;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_pend <= smw_pkg::PEND_RST;
      end else begin
         rd_pend <= {rd_pend[1:0], busy && !cur_write &&
                     cnt == smw_pkg::EFF_W'(ctl_end - smw_pkg::ONE_CNT)};
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_valid_o <= 1'b0;
         rd_data_o <= smw_pkg::DATA_RST;
      end else begin
         rd_valid_o <= rd_pend[2]; // R10 R11
         if (rd_pend[2]) begin
            rd_data_o <= data_sync2;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   sequence cap_seq;
      rd_pend[0] ##1 rd_pend[1] ##1 rd_pend[2] ##1 rd_valid_o;
   endsequence

   sequence rd_b2b_seq;
      (busy && !cur_write && last && take && !req_write_i && s_lo)
      ##1 s_lo;
   endsequence

   idle_lines_high_a: assert property ( // R24
      !$past(busy) |-> read_strobe_n_o && write_strobe_n_o &&
      (&chip_select_line_n_o) && (&byte_write_strobe_n_o) &&
      (&byte_select_line_n_o))
      else $error("control line active while idle");

   rd_strobe_fall_a: assert property ( // R03
      busy && !cur_write && cnt == s_setup |=> !read_strobe_n_o)
      else $error("read strobe not low after setup");

   rd_strobe_hold_a: assert property ( // R05
      busy && !cur_write && cnt >= s_end |=> read_strobe_n_o)
      else $error("read strobe low during hold");

   cs_read_fall_a: assert property ( // R04
      busy && !cur_write && cnt == c_setup |=>
      !chip_select_line_n_o[$past(cur_cs)])
      else $error("chip select not low after read setup");

   cycle_bound_a: assert property ( // R15
      busy |-> cnt < cyc)
      else $error("access counter past cycle count");

   read_capture_a: assert property ( // R10
      busy && !cur_write &&
      cnt == smw_pkg::EFF_W'(ctl_end - smw_pkg::ONE_CNT) |=> cap_seq)
      else $error("read data not captured after strobe rise");

   rd_continuous_a: assert property ( // R07
      rd_b2b_seq |=> !read_strobe_n_o && !$past(read_strobe_n_o))
      else $error("read strobe released between reads");

   wr_data_drive_a: assert property ( // R20
      busy && cur_write && cnt >= wctl_setup |=> data_oe_o)
      else $error("write data not driven after setup");

   oe_release_a: assert property ( // R25
      !busy || !cur_write |=> !data_oe_o)
      else $error("data driven outside a write");

   byte_write_a: assert property ( // R13
      busy && cur_write && cur_bwr |=> write_strobe_n_o &&
      byte_write_strobe_n_o == ({smw_pkg::LANES{!$past(s_lo)}} |
                                ~$past(cur_lanes)))
      else $error("byte write line differs from strobe");

   addr_stable_a: assert property ( // R01
      busy && cnt != smw_pkg::CNT_RST |=> $stable(addr_o) &&
      $stable(byte_select_line_n_o))
      else $error("address or byte select moved in access");

   addr_align_a: assert property ( // R02
      busy && cur_dbw == smw_pkg::DBW_32 |=> addr_o[1:0] == 2'h0)
      else $error("word address not aligned");

endmodule

// file: core/smw_pkg.sv
// Shared constants, types and field decoders of the static memory strobe generator
package smw_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int CS_NUM = 8;
   localparam int CS_W = 3;
   localparam int ADDR_W = 26;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int SETUP_W = 6;
   localparam int PULSE_W = 7;
   localparam int CYCLE_W = 9;
   localparam int EFF_W = 10;
   localparam int SYNC_STAGES = 2;
   localparam int CAP_DLY = 3;

   // ----------------------------------------------------------------
   // Field weights and counts
   // ----------------------------------------------------------------
   localparam logic [EFF_W-1:0] SETUP_HI_WT = 10'h080;
   localparam logic [EFF_W-1:0] PULSE_HI_WT = 10'h100;
   localparam logic [EFF_W-1:0] CYCLE_HI_WT = 10'h100;
   localparam logic [EFF_W-1:0] MIN_CYCLE = 10'h001;
   localparam logic [EFF_W-1:0] ONE_CNT = 10'h001;
   localparam logic [EFF_W-1:0] TWO_CNT = 10'h002;

   // ----------------------------------------------------------------
   // Data bus width codes
   // ----------------------------------------------------------------
   localparam logic [1:0] DBW_8 = 2'h0;
   localparam logic [1:0] DBW_16 = 2'h1;
   localparam logic [1:0] DBW_32 = 2'h2;

   // ----------------------------------------------------------------
   // Reset and idle values
   // ----------------------------------------------------------------
   localparam logic [EFF_W-1:0] CNT_RST = 10'h000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 26'h0000000;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [CS_NUM-1:0] CS_IDLE = 8'hff;
   localparam logic [CS_NUM-1:0] CS_ONE = 8'h01;
   localparam logic [LANES-1:0] LANES_IDLE = 4'hf;
   localparam logic [CS_W-1:0] CS_RST = 3'h0;
   localparam logic [CAP_DLY-1:0] PEND_RST = 3'h0;
   localparam logic [SYNC_STAGES*DATA_W-1:0] SYNC_RST = 64'h0;

   typedef enum logic {
      SMW_IDLE = 1'b0,
      SMW_ACCESS = 1'b1
   } smw_state_e;

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------
   function automatic logic [EFF_W-1:0] smw_dec_setup(
      input logic [SETUP_W-1:0] f);
      return (f[5] ? SETUP_HI_WT : CNT_RST) + {5'h00, f[4:0]};
   endfunction

   function automatic logic [EFF_W-1:0] smw_dec_pulse(
      input logic [PULSE_W-1:0] f);
      return (f[6] ? PULSE_HI_WT : CNT_RST) + {4'h0, f[5:0]};
   endfunction

   function automatic logic [EFF_W-1:0] smw_dec_cycle(
      input logic [CYCLE_W-1:0] f);
      return ({8'h00, f[8:7]} * CYCLE_HI_WT) + {3'h0, f[6:0]};
   endfunction

   function automatic logic [LANES-1:0] smw_lanes(input logic [1:0] dbw);
      return (dbw == DBW_8) ? 4'h1 : ((dbw == DBW_16) ? 4'h3 : 4'hf);
   endfunction

endpackage

// file: core/smw_cfg_decode.sv
// Decodes the timing fields of one access into effective cycle counts
`timescale 1ns/1ps
module smw_cfg_decode (
   // Coded fields of the selected direction
   input wire logic [smw_pkg::SETUP_W-1:0] strobe_setup_i,
   input wire logic [smw_pkg::PULSE_W-1:0] strobe_pulse_i,
   input wire logic [smw_pkg::SETUP_W-1:0] cs_setup_i,
   input wire logic [smw_pkg::PULSE_W-1:0] cs_pulse_i,
   input wire logic [smw_pkg::CYCLE_W-1:0] cycle_i,
   // Effective counts
   output logic [smw_pkg::EFF_W-1:0] strobe_setup_o,
   output logic [smw_pkg::EFF_W-1:0] strobe_pulse_o,
   output logic [smw_pkg::EFF_W-1:0] cs_setup_o,
   output logic [smw_pkg::EFF_W-1:0] cs_pulse_o,
   output logic [smw_pkg::EFF_W-1:0] cycle_o
);

   logic [smw_pkg::EFF_W-1:0] raw_cycle;

   assign strobe_setup_o = smw_pkg::smw_dec_setup(strobe_setup_i);
   assign strobe_pulse_o = smw_pkg::smw_dec_pulse(strobe_pulse_i);
   assign cs_setup_o = smw_pkg::smw_dec_setup(cs_setup_i);
   assign cs_pulse_o = smw_pkg::smw_dec_pulse(cs_pulse_i);
   assign raw_cycle = smw_pkg::smw_dec_cycle(cycle_i);
   // A zero cycle would wrap the counter through 1024 cycles; it is run as one cycle
   assign cycle_o = (raw_cycle < smw_pkg::MIN_CYCLE) ?
                    smw_pkg::MIN_CYCLE : raw_cycle;

endmodule

// file: core/smw_strobe_win.sv
// Active window of one strobe within the access counter
`timescale 1ns/1ps
module smw_strobe_win (
   // Counter and programmed shape
   input wire logic [smw_pkg::EFF_W-1:0] cnt_i,
   input wire logic [smw_pkg::EFF_W-1:0] setup_i,
   input wire logic [smw_pkg::EFF_W-1:0] pulse_i,
   // Window
   output logic active_o,
   output logic [smw_pkg::EFF_W-1:0] end_o
);

   assign end_o = smw_pkg::EFF_W'(setup_i + pulse_i);
   assign active_o = (cnt_i >= setup_i) && (cnt_i < end_o);

endmodule

// file: tb/smw_mem_model.sv
// Asynchronous memory or display module answering reads on the data pins
`timescale 1ns/1ps
module smw_mem_model (
   // Pins from the controller
   input wire logic read_strobe_n_i,
   input wire logic [7:0] chip_select_line_n_i,
   // Device kind: 1 valid while selected, 0 valid while read strobe low
   input wire logic lcd_type_i,
   input wire logic [31:0] word_i,
   // Data pins back to the controller
   output logic [31:0] data_o
);
   logic en;
   // Outside its valid window the bus shows the inverse, not a stale copy
   assign en = lcd_type_i ? ~&chip_select_line_n_i : ~read_strobe_n_i;
   assign data_o = en ? word_i : ~word_i;
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the static memory strobe generator
`timescale 1ns/1ps
module tb_top;
   logic clock_i, sys_rst_i, req_valid_i, req_write_i, req_ready_o;
   logic rd_valid_o, write_strobe_n_o, read_strobe_n_o, data_oe_o, lcd;
   logic [2:0] req_cs_i, cc;
   logic [25:0] req_addr_i, addr_o, a_s;
   logic [3:0] req_be_i, byte_select_line_n_o, byte_write_strobe_n_o;
   logic [3:0] b_s, bwx;
   logic [31:0] req_wdata_i, rd_data_o, data_o, data_i, word, d_s;
   logic [7:0] chip_select_line_n_o, byte_write_mode_i;
   logic [7:0] read_mode_i, write_mode_i;
   logic [7:0][5:0] rd_strobe_setup_cnt_i, cs_read_setup_cnt_i;
   logic [7:0][5:0] wr_strobe_setup_cnt_i, cs_write_setup_cnt_i;
   logic [7:0][6:0] rd_strobe_pulse_cnt_i, cs_read_pulse_cnt_i;
   logic [7:0][6:0] wr_strobe_pulse_cnt_i, cs_write_pulse_cnt_i;
   logic [7:0][8:0] rd_cycle_cnt_i, wr_cycle_cnt_i;
   logic [7:0][1:0] data_width_i;
   int n_errors, tests_run, t, n_st, n_sf, f_st, l_st, n_cs, f_cs;
   int n_oe, n_bw, n_rv;
   bit st, p_st;
   smw_waveform_gen dut_u (.clock_i, .sys_rst_i, .req_valid_i,
      .req_write_i, .req_cs_i, .req_addr_i, .req_be_i, .req_wdata_i,
      .req_ready_o, .rd_valid_o, .rd_data_o, .rd_strobe_setup_cnt_i,
      .rd_strobe_pulse_cnt_i, .rd_cycle_cnt_i, .cs_read_setup_cnt_i,
      .cs_read_pulse_cnt_i, .wr_strobe_setup_cnt_i, .wr_strobe_pulse_cnt_i,
      .wr_cycle_cnt_i, .cs_write_setup_cnt_i, .cs_write_pulse_cnt_i,
      .data_width_i, .byte_write_mode_i, .read_mode_i, .write_mode_i,
      .addr_o, .byte_select_line_n_o, .write_strobe_n_o,
      .byte_write_strobe_n_o, .read_strobe_n_o, .chip_select_line_n_o,
      .data_o, .data_oe_o, .data_i);
   smw_mem_model mem_u (.read_strobe_n_i(read_strobe_n_o),
      .chip_select_line_n_i(chip_select_line_n_o), .lcd_type_i(lcd),
      .word_i(word), .data_o(data_i));
   initial begin
      clock_i = 0;
      forever #5 clock_i = ~clock_i;
   end
   // ----------------------------------------------------------------
   // Pin monitor, sampled where outputs are settled
   // ----------------------------------------------------------------
   always @(negedge clock_i) begin
      t++;
      st = (read_strobe_n_o === 1'b0) || (write_strobe_n_o === 1'b0);
      if (st) n_st++;
      if (st && !p_st) begin
         n_sf++;
         l_st = t;
         if (f_st < 0) begin
            f_st = t;
            a_s = addr_o;
            b_s = byte_select_line_n_o;
            d_s = data_o;
         end
      end
      p_st = st;
      if (chip_select_line_n_o === ~(8'h01 << cc)) begin
         n_cs++;
         if (f_cs < 0) f_cs = t;
      end
      if (data_oe_o === 1'b1) n_oe++;
      if (byte_write_strobe_n_o === bwx) n_bw++;
      if (rd_valid_o === 1'b1) n_rv++;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cfg(input logic [2:0] c, input logic [5:0] ss,
         input logic [6:0] sp, input logic [5:0] cs, input logic [6:0] cp,
         input logic [8:0] cy);
      // Callers keep pulses nonzero and setup plus pulse within the cycle
      rd_strobe_setup_cnt_i[c] = ss;
      rd_strobe_pulse_cnt_i[c] = sp;
      cs_read_setup_cnt_i[c] = cs;
      cs_read_pulse_cnt_i[c] = cp;
      rd_cycle_cnt_i[c] = cy;
      wr_strobe_setup_cnt_i[c] = ss;
      wr_strobe_pulse_cnt_i[c] = sp;
      cs_write_setup_cnt_i[c] = cs;
      cs_write_pulse_cnt_i[c] = cp;
      wr_cycle_cnt_i[c] = cy;
      n_st = 0; n_sf = 0; n_cs = 0; n_oe = 0; n_bw = 0; n_rv = 0;
      f_st = -1; f_cs = -1; cc = c;
   endtask
   task automatic acc(input logic w, input logic [25:0] a,
         input logic [3:0] be, input logic h);
      int k;
      req_write_i = w; req_cs_i = cc; req_addr_i = a; req_be_i = be;
      req_wdata_i = word; req_valid_i = 1;
      k = 0;
      while (req_ready_o !== 1'b1 && k < 3000) begin
         @(posedge clock_i); #1; k++;
      end
      @(posedge clock_i); #1;
      if (!h) req_valid_i = 0;
   endtask
   task automatic fin();
      int k;
      k = 0;
      while (req_ready_o !== 1'b1 && k < 3000) begin
         @(posedge clock_i); #1; k++;
      end
      repeat (8) @(posedge clock_i);
      #1;
      chk("idle", {read_strobe_n_o, write_strobe_n_o, byte_write_strobe_n_o,
         chip_select_line_n_o, data_oe_o}, 32'h00007ffe);
   endtask
   task automatic complete_run();
      $display("errors %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      complete_run();
   end
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      sys_rst_i = 1; req_valid_i = 0; req_write_i = 0; req_cs_i = 0;
      req_addr_i = 0; req_be_i = 0; req_wdata_i = 0; lcd = 0; cc = 0;
      word = 32'h5a3c96e1; bwx = 4'ha; byte_write_mode_i = 8'h20;
      read_mode_i = 8'h0a; write_mode_i = 8'hd0; data_width_i = {8{2'h2}};
      data_width_i[2] = 2'h1;
      {rd_strobe_setup_cnt_i, cs_read_setup_cnt_i} = '0;
      {wr_strobe_setup_cnt_i, cs_write_setup_cnt_i} = '0;
      {rd_strobe_pulse_cnt_i, cs_read_pulse_cnt_i} = '0;
      {wr_strobe_pulse_cnt_i, cs_write_pulse_cnt_i} = '0;
      {rd_cycle_cnt_i, wr_cycle_cnt_i} = '0;
      repeat (8) @(posedge clock_i);
      #1 sys_rst_i = 0;
      cfg(3'h1, 6'h02, 7'h03, 6'h01, 7'h06, 9'h008);
      acc(0, 26'h0000007, 4'hf, 1);
      acc(0, 26'h0000007, 4'hf, 0);
      fin();
      chk("rd pulse", n_st, 6);
      chk("cs pulse", n_cs, 12);
      chk("rd setup", f_st - f_cs, 1);
      chk("rd cycle", l_st - f_st, 8);
      chk("rd count", n_rv, 2);
      chk("rd data", rd_data_o, word);
      chk("addr 32", a_s, 26'h0000004);
      chk("bsel 32", b_s, 4'h0);
      lcd = 1; word = 32'hc3a50f1e;
      cfg(3'h2, 6'h00, 7'h07, 6'h02, 7'h03, 9'h007);
      acc(0, 26'h0000003, 4'hf, 0);
      fin();
      chk("cs data", rd_data_o[15:0], word[15:0]);
      chk("addr 16", a_s, 26'h0000002);
      chk("bsel 16", b_s, 4'hc);
      lcd = 0;
      cfg(3'h3, 6'h00, 7'h04, 6'h00, 7'h04, 9'h004);
      acc(0, 26'h0000010, 4'hf, 1);
      acc(0, 26'h0000014, 4'hf, 0);
      fin();
      chk("rd merged", n_st, 8);
      chk("rd falls", n_sf, 1);
      chk("cs merged", n_cs, 8);
      cfg(3'h4, 6'h02, 7'h03, 6'h01, 7'h05, 9'h007);
      acc(1, 26'h0000010, 4'hf, 0);
      fin();
      chk("wr pulse", n_st, 3);
      chk("wr cs", n_cs, 5);
      chk("wr setup", f_st - f_cs, 1);
      chk("wr drive", n_oe, 5);
      chk("wr data", d_s, word);
      cfg(3'h5, 6'h01, 7'h02, 6'h03, 7'h02, 9'h006);
      acc(1, 26'h0000020, 4'h5, 0);
      fin();
      chk("bw lines", n_bw, 2);
      chk("bw cs", n_cs, 2);
      chk("cs drive", n_oe, 3);
      cfg(3'h6, 6'h21, 7'h01, 6'h01, 7'h41, 9'h104);
      acc(1, 26'h0000040, 4'hf, 0);
      fin();
      chk("dec setup", f_st - f_cs, 128);
      chk("dec pulse", n_cs, 257);
      chk("dec cycle", n_oe, 387);
      cfg(3'h7, 6'h00, 7'h02, 6'h00, 7'h02, 9'h002);
      acc(1, 26'h0000080, 4'hf, 1);
      acc(1, 26'h0000084, 4'hf, 0);
      fin();
      chk("wr merged", n_st, 4);
      chk("wr falls", n_sf, 1);
      complete_run();
   end
endmodule
